// ---- src/fsb_pkg.sv ----
package fsb_pkg;

	localparam int DATA_W  = 32;
	localparam int REG_AW  = 8;
	localparam int NUM_CHK = 6;
	localparam int NUM_RGN = 4;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] OFS_ENABLE       = 8'h00;
	localparam logic [7:0] OFS_STATUS       = 8'h04;
	localparam logic [7:0] OFS_CLEAR        = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN       = 8'h0C;
	localparam logic [7:0] OFS_CAUSE        = 8'h10;
	localparam logic [7:0] OFS_RESUME       = 8'h14;
	localparam logic [7:0] OFS_STACK_TOP    = 8'h18;
	localparam logic [7:0] OFS_STACK_BOTTOM = 8'h1C;
	// Region bounds: region n low at 0x20 + 8n, high at 0x24 + 8n.
	localparam logic [7:0] OFS_REGION_BASE  = 8'h20;

	// Check positions in ENABLE, STATUS, CLEAR, IRQ_EN and CAUSE.
	localparam int CHK_FETCH  = 0;
	localparam int CHK_WRITE  = 1;
	localparam int CHK_SFR_RD = 2;
	localparam int CHK_SFR_WR = 3;
	localparam int CHK_OVF    = 4;
	localparam int CHK_UNF    = 5;

	// Region indices.
	localparam int RGN_FETCH  = 0;
	localparam int RGN_WRITE  = 1;
	localparam int RGN_SFR_RD = 2;
	localparam int RGN_SFR_WR = 3;

	localparam logic [NUM_CHK-1:0] ENABLE_RST = 6'h0F;
	localparam int                 CAUSE_HALT_BIT = 8;
	localparam int                 RESUME_BIT     = 0;

	typedef enum logic [1:0] {
		MON_RUN  = 2'h1,
		MON_HALT = 2'h2
	} mon_state_e;

endpackage

// ---- src/fail_safe_break_monitor.sv ----
// Behaviour
// - Enabled fetch check halts right after a fetch from the fetch-protected region; default on.
// - Enabled write check halts right after a write into the write-protected region; default on.
// - Enabled SFR read check halts right after reading a read-protected SFR; default on.
// - Enabled SFR write check halts right after writing a write-protected SFR; default on.
// - A disabled check never stops execution, even on a violating access.
// - Enabled overflow check halts right after a user stack overflow; default off.
// - Stack top address is settable over the full address range; resets to stack end symbol.
// - Enabled underflow check halts right after a user stack underflow; default off.
// - Stack bottom address has the same range; resets to the stack begin symbol.
//
// Our own choices: the register offsets and the strobed register port.
module fail_safe_break_monitor #(
	parameter int                ADDR_W             = 20,
	parameter logic [ADDR_W-1:0] STACK_END_SYMBOL   = 20'h0,
	parameter logic [ADDR_W-1:0] STACK_BEGIN_SYMBOL = 20'hFFFFF
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	input  wire logic                       clkEn,
	input  wire logic                       cpuValid,
	input  wire logic [ADDR_W-1:0]          cpuAddr,
	input  wire logic                       cpuFetch,
	input  wire logic                       cpuRead,
	input  wire logic                       cpuWrite,
	input  wire logic                       cpuSfr,
	input  wire logic                       cpuStack,
	input  wire logic [fsb_pkg::REG_AW-1:0] regAddr,
	input  wire logic [fsb_pkg::DATA_W-1:0] regWdata,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic      [fsb_pkg::DATA_W-1:0] regRdata,
	output logic                            haltReq,
	output logic                            irq
);
	import fsb_pkg::*;

	// Both bounds are inclusive, so a one-address region has equal low and high.
	function automatic logic inRange(input logic [ADDR_W-1:0] a,
	                                 input logic [ADDR_W-1:0] lo,
	                                 input logic [ADDR_W-1:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Configuration and status state.

	logic [NUM_CHK-1:0] enable;
	logic [NUM_CHK-1:0] next_enable;
	logic [NUM_CHK-1:0] status;
	logic [NUM_CHK-1:0] next_status;
	logic [NUM_CHK-1:0] irqEn;
	logic [NUM_CHK-1:0] next_irqEn;
	logic [NUM_CHK-1:0] cause;
	logic [NUM_CHK-1:0] next_cause;
	logic [ADDR_W-1:0]  stackTop;
	logic [ADDR_W-1:0]  next_stackTop;
	logic [ADDR_W-1:0]  stackBottom;
	logic [ADDR_W-1:0]  next_stackBottom;
	logic [ADDR_W-1:0]  regionLo [NUM_RGN];
	logic [ADDR_W-1:0]  next_regionLo [NUM_RGN];
	logic [ADDR_W-1:0]  regionHi [NUM_RGN];
	logic [ADDR_W-1:0]  next_regionHi [NUM_RGN];
	mon_state_e         state;
	mon_state_e         next_state;
	logic               next_haltReq;
	logic               next_irq;
	logic [DATA_W-1:0]  next_regRdata;

	logic [NUM_RGN-1:0] regionHit;
	logic [NUM_CHK-1:0] rawViol;
	logic [NUM_CHK-1:0] violEn;
	logic [NUM_CHK-1:0] clearMask;
	logic               resumeReq;
	logic               regionSel;
	logic [1:0]         regionIdx;

	////////////////////////////////////////////////////////////////////////////
	// Violation detection on the observed core access.

	for (genvar g = 0; g < NUM_RGN; g++) begin : g_region
		assign regionHit[g] = inRange(cpuAddr, regionLo[g], regionHi[g]);
	end

	always_comb begin
		rawViol             = '0;
		rawViol[CHK_FETCH]  = cpuValid && cpuFetch && regionHit[RGN_FETCH];
		rawViol[CHK_WRITE]  = cpuValid && cpuWrite && !cpuSfr && regionHit[RGN_WRITE];
		rawViol[CHK_SFR_RD] = cpuValid && cpuRead && cpuSfr && regionHit[RGN_SFR_RD];
		rawViol[CHK_SFR_WR] = cpuValid && cpuWrite && cpuSfr && regionHit[RGN_SFR_WR];
		// The stack grows downward, so the top is the lowest legal address.
		rawViol[CHK_OVF]    = cpuValid && cpuStack && (cpuAddr < stackTop);
		rawViol[CHK_UNF]    = cpuValid && cpuStack && (cpuAddr > stackBottom);
		violEn              = rawViol & enable;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port decode.

	// Region words sit in pairs: bits 4:3 pick the region and bit 2 the bound.
	// A region whose low exceeds its high never matches, which is how one is left unused.
	assign regionSel = regAddr[7:5] == OFS_REGION_BASE[7:5];
	assign regionIdx = regAddr[4:3];
	assign clearMask = (regWr && regAddr == OFS_CLEAR) ? regWdata[NUM_CHK-1:0] : '0;
	assign resumeReq = regWr && regAddr == OFS_RESUME && regWdata[RESUME_BIT];

	always_comb begin
		next_enable      = enable;
		next_irqEn       = irqEn;
		next_stackTop    = stackTop;
		next_stackBottom = stackBottom;
		next_regionLo    = regionLo;
		next_regionHi    = regionHi;
		if (regWr) begin
			if (regAddr == OFS_ENABLE) begin
				next_enable = regWdata[NUM_CHK-1:0];
			end else if (regAddr == OFS_IRQ_EN) begin
				next_irqEn = regWdata[NUM_CHK-1:0];
			end else if (regAddr == OFS_STACK_TOP) begin
				next_stackTop = regWdata[ADDR_W-1:0];
			end else if (regAddr == OFS_STACK_BOTTOM) begin
				next_stackBottom = regWdata[ADDR_W-1:0];
			end else if (regionSel && !regAddr[2]) begin
				next_regionLo[regionIdx] = regWdata[ADDR_W-1:0];
			end else if (regionSel && regAddr[2]) begin
				next_regionHi[regionIdx] = regWdata[ADDR_W-1:0];
			end
		end
	end

	// Read data fall back to zero after one cycle, so a stale word is never
	// mistaken for a fresh answer when a strobe was lost on the way.
	always_comb begin
		next_regRdata = '0;
		if (regRd) begin
			if (regAddr == OFS_ENABLE) begin
				next_regRdata[NUM_CHK-1:0] = enable;
			end else if (regAddr == OFS_STATUS) begin
				next_regRdata[NUM_CHK-1:0] = status;
			end else if (regAddr == OFS_IRQ_EN) begin
				next_regRdata[NUM_CHK-1:0] = irqEn;
			end else if (regAddr == OFS_CAUSE) begin
				next_regRdata[NUM_CHK-1:0]   = cause;
				next_regRdata[CAUSE_HALT_BIT] = haltReq;
			end else if (regAddr == OFS_STACK_TOP) begin
				next_regRdata[ADDR_W-1:0] = stackTop;
			end else if (regAddr == OFS_STACK_BOTTOM) begin
				next_regRdata[ADDR_W-1:0] = stackBottom;
			end else if (regionSel && !regAddr[2]) begin
				next_regRdata[ADDR_W-1:0] = regionLo[regionIdx];
			end else if (regionSel && regAddr[2]) begin
				next_regRdata[ADDR_W-1:0] = regionHi[regionIdx];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Break state, cause capture, sticky status and interrupt.

	// The halt is a level that stands until software resumes, so a stop that
	// lands while the debugger is busy elsewhere is never lost.
	always_comb begin
		next_state   = state;
		next_cause   = cause;
		// A new event wins over a clear written in the same cycle.
		next_status  = (status & ~clearMask) | violEn;
		case (state)
			MON_RUN: begin
				if (violEn != '0) begin
					next_state = MON_HALT;
					next_cause = violEn;
				end
			end
			MON_HALT: begin
				// A fresh violation wins over a resume in the same cycle, so the halt stands.
				if (violEn != '0) begin
					next_cause = violEn;
				end else if (resumeReq) begin
					next_state = MON_RUN;
				end
			end
			default: begin
				next_state = MON_RUN;
			end
		endcase
		next_haltReq = next_state == MON_HALT;
		next_irq     = |(next_status & irqEn);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			enable      <= ENABLE_RST;
			irqEn       <= '0;
			status      <= '0;
			cause       <= '0;
			stackTop    <= STACK_END_SYMBOL;
			stackBottom <= STACK_BEGIN_SYMBOL;
			// Regions reset empty, so nothing can halt the core until software
			// has programmed a range on purpose.
			for (int i = 0; i < NUM_RGN; i++) begin
				regionLo[i] <= '1;
				regionHi[i] <= '0;
			end
			state       <= MON_RUN;
			haltReq     <= 1'b0;
			irq         <= 1'b0;
			regRdata    <= '0;
		end else if (clkEn) begin
			enable      <= next_enable;
			irqEn       <= next_irqEn;
			status      <= next_status;
			cause       <= next_cause;
			stackTop    <= next_stackTop;
			stackBottom <= next_stackBottom;
			regionLo    <= next_regionLo;
			regionHi    <= next_regionHi;
			state       <= next_state;
			haltReq     <= next_haltReq;
			irq         <= next_irq;
			regRdata    <= next_regRdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	chk_fetch_halt: assert property (
		clkEn && enable[CHK_FETCH] && cpuValid && cpuFetch && regionHit[RGN_FETCH]
		|=> haltReq && status[CHK_FETCH])
		else $error("Fetch from protected region did not halt.");

	chk_write_halt: assert property (
		clkEn && enable[CHK_WRITE] && cpuValid && cpuWrite && !cpuSfr
		&& regionHit[RGN_WRITE] |=> haltReq && status[CHK_WRITE])
		else $error("Write to protected region did not halt.");

	chk_sfr_read: assert property (
		clkEn && enable[CHK_SFR_RD] && cpuValid && cpuRead && cpuSfr
		&& regionHit[RGN_SFR_RD] |=> haltReq && status[CHK_SFR_RD])
		else $error("Protected SFR read did not halt.");

	chk_sfr_write: assert property (
		clkEn && enable[CHK_SFR_WR] && cpuValid && cpuWrite && cpuSfr
		&& regionHit[RGN_SFR_WR] |=> haltReq && status[CHK_SFR_WR])
		else $error("Protected SFR write did not halt.");

	chk_disabled_quiet: assert property (
		clkEn && !haltReq && (rawViol & enable) == '0 |=> !haltReq)
		else $error("Halt raised without an enabled violation.");

	chk_stack_over: assert property (
		clkEn && enable[CHK_OVF] && cpuValid && cpuStack && cpuAddr < stackTop
		|=> haltReq && status[CHK_OVF])
		else $error("Stack overflow did not halt.");

	chk_stack_under: assert property (
		clkEn && enable[CHK_UNF] && cpuValid && cpuStack && cpuAddr > stackBottom
		|=> haltReq && status[CHK_UNF])
		else $error("Stack underflow did not halt.");

	chk_stack_limits: assert property (
		clkEn && regWr && regAddr == OFS_STACK_TOP
		|=> stackTop == $past(regWdata[ADDR_W-1:0]))
		else $error("Stack top write not taken.");

	chk_stack_bottom: assert property (
		clkEn && regWr && regAddr == OFS_STACK_BOTTOM
		|=> stackBottom == $past(regWdata[ADDR_W-1:0]))
		else $error("Stack bottom write not taken.");

	chk_cause_record: assert property (
		$rose(haltReq) |-> cause == $past(violEn) && cause != '0)
		else $error("Halt cause not recorded.");

	chk_halt_holds: assert property (
		haltReq && !(clkEn && resumeReq) |=> haltReq)
		else $error("Halt dropped without a resume.");

	chk_cause_overwrite: assert property (
		clkEn && haltReq && violEn != '0 |=> haltReq && cause == $past(violEn))
		else $error("Violation while halted not recorded.");

	chk_status_sticky: assert property (
		clkEn |=> ($past(status) & ~$past(clearMask) & ~status) == '0)
		else $error("Status bit lost without a clear.");

	chk_top_readback: assert property (
		clkEn && regRd && regAddr == OFS_STACK_TOP
		|=> regRdata[ADDR_W-1:0] == $past(stackTop) && regRdata[DATA_W-1:ADDR_W] == '0)
		else $error("Stack top read back wrong.");

	chk_bottom_readback: assert property (
		clkEn && regRd && regAddr == OFS_STACK_BOTTOM
		|=> regRdata[ADDR_W-1:0] == $past(stackBottom) && regRdata[DATA_W-1:ADDR_W] == '0)
		else $error("Stack bottom read back wrong.");

	// Main scenarios: a fetch, an SFR write and a stack overflow stop, a resume, and a violation that is masked.
	cov_fetch_halt: cover property (clkEn && violEn[CHK_FETCH] && !haltReq ##1 haltReq);
	cov_stack_halt: cover property (clkEn && violEn[CHK_OVF] ##1 haltReq);
	cov_resume: cover property (haltReq && clkEn && resumeReq ##1 !haltReq);
	cov_sfr_halt: cover property (clkEn && violEn[CHK_SFR_WR] && !haltReq ##1 haltReq);
	cov_masked_viol: cover property (clkEn && rawViol != '0 && violEn == '0);

endmodule

// ---- verif/cpu_core_model.sv ----
module cpu_core_model #(
	parameter int AW = 20
) (
	input  wire logic          ref_clk,
	output logic               cpuValid,
	output logic      [AW-1:0] cpuAddr,
	output logic               cpuFetch,
	output logic               cpuRead,
	output logic               cpuWrite,
	output logic               cpuSfr,
	output logic               cpuStack
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cpuValid = 1'b0;
		cpuAddr = '0;
		{cpuFetch, cpuRead, cpuWrite, cpuSfr, cpuStack} = 5'h00;
	end
	////////////////////////////////////////
	// Between accesses the lines show the inverse of the last access, so a
	// monitor that ignores cpuValid cannot pass by luck.
	task automatic access(input logic [AW-1:0] a, input logic [4:0] k);
		@(posedge ref_clk);
		cpuValid <= 1'b1;
		cpuAddr <= a;
		{cpuFetch, cpuRead, cpuWrite, cpuSfr, cpuStack} <= k;
		@(posedge ref_clk);
		cpuValid <= 1'b0;
		cpuAddr <= ~a;
		{cpuFetch, cpuRead, cpuWrite, cpuSfr, cpuStack} <= ~k;
	endtask
endmodule

// ---- verif/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import fsb_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rstn;
	logic        clkEn;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRdata;
	logic        haltReq;
	logic        irq;
	logic        cpuValid;
	logic [19:0] cpuAddr;
	logic        cpuFetch;
	logic        cpuRead;
	logic        cpuWrite;
	logic        cpuSfr;
	logic        cpuStack;
	int          errTotal = 0;
	int          testsRun = 0;
	logic [4:0]  kinds [4] = '{5'h10, 5'h04, 5'h0A, 5'h06};

	always #4 ref_clk = ~ref_clk;

	fail_safe_break_monitor i_fail_safe_break_monitor (.ref_clk(ref_clk), .rstn(rstn),
		.clkEn(clkEn), .cpuValid(cpuValid), .cpuAddr(cpuAddr), .cpuFetch(cpuFetch),
		.cpuRead(cpuRead), .cpuWrite(cpuWrite), .cpuSfr(cpuSfr), .cpuStack(cpuStack),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .haltReq(haltReq), .irq(irq));
	cpu_core_model i_cpu_core_model (.ref_clk(ref_clk), .cpuValid(cpuValid),
		.cpuAddr(cpuAddr), .cpuFetch(cpuFetch), .cpuRead(cpuRead), .cpuWrite(cpuWrite),
		.cpuSfr(cpuSfr), .cpuStack(cpuStack));

	////////////////////////////////////////
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e) begin
			errTotal++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		cmp(regRdata, e);
	endtask
	// Resume, then clear every status bit so the next case starts clean.
	task automatic release_halt();
		reg_wr(OFS_RESUME, 32'h1);
		reg_wr(OFS_CLEAR, 32'h3F);
		cmp({30'h0, haltReq, irq}, 32'h0);
	endtask
	////////////////////////////////////////
	task automatic check_defaults();
		reg_rd(OFS_ENABLE, 32'h0F);
		reg_rd(OFS_STACK_TOP, 32'h0);
		reg_rd(OFS_STACK_BOTTOM, 32'hFFFFF);
		reg_wr(OFS_STATUS, 32'h3F);
		reg_rd(OFS_STATUS, 32'h0);
		reg_rd(8'hFC, 32'h0);
	endtask
	task automatic check_regions();
		logic [31:0] lo;
		reg_wr(OFS_IRQ_EN, 32'h3F);
		for (int n = 0; n < 4; n++) begin
			lo = 32'h100 * (n + 1);
			reg_wr(8'(OFS_REGION_BASE + 8 * n), lo);
			reg_wr(8'(OFS_REGION_BASE + 8 * n + 4), lo + 32'hF);
		end
		reg_rd(OFS_IRQ_EN, 32'h3F);
		reg_rd(8'h3C, 32'h40F);
		// Odd regions are hit at their high bound, even ones at the low bound.
		for (int n = 0; n < 4; n++) begin
			i_cpu_core_model.access(20'(32'h100 * (n + 1) + 15 * (n % 2)), kinds[n]);
			#1;
			cmp({30'h0, haltReq, irq}, 32'h3);
			reg_rd(OFS_STATUS, 32'(1 << n));
			reg_rd(OFS_CAUSE, 32'h100 | 32'(1 << n));
			release_halt();
		end
	endtask
	task automatic check_disabled();
		reg_wr(OFS_ENABLE, 32'h0);
		reg_wr(OFS_STACK_TOP, 32'h800);
		reg_wr(OFS_STACK_BOTTOM, 32'h900);
		for (int n = 0; n < 4; n++) begin
			i_cpu_core_model.access(20'(32'h100 * (n + 1)), kinds[n]);
			#1;
			cmp({30'h0, haltReq, irq}, 32'h0);
		end
		// Both stack accesses break a limit, but their checks are off.
		i_cpu_core_model.access(20'h00000, 5'h05);
		i_cpu_core_model.access(20'hFFFFF, 5'h05);
		#1;
		cmp({30'h0, haltReq, irq}, 32'h0);
		reg_rd(OFS_STATUS, 32'h0);
	endtask
	task automatic check_stack();
		logic [19:0] ad [4] = '{20'h00800, 20'h00900, 20'h007FF, 20'h00901};
		logic [31:0] ca [4] = '{32'h0, 32'h0, 32'h10, 32'h20};
		reg_wr(OFS_ENABLE, 32'h30);
		reg_wr(OFS_IRQ_EN, 32'h0);
		reg_wr(OFS_STACK_TOP, 32'hFFFFF);
		reg_rd(OFS_STACK_TOP, 32'hFFFFF);
		reg_wr(OFS_STACK_TOP, 32'h800);
		reg_wr(OFS_STACK_BOTTOM, 32'h900);
		reg_rd(OFS_STACK_BOTTOM, 32'h900);
		for (int i = 0; i < 4; i++) begin
			i_cpu_core_model.access(ad[i], 5'h05);
			#1;
			cmp({30'h0, haltReq, irq}, {30'h0, ca[i] != 0, 1'b0});
			if (ca[i] != 0) begin
				reg_rd(OFS_CAUSE, 32'h100 | ca[i]);
				release_halt();
			end
		end
	endtask
	////////////////////////////////////////
	task automatic tallyAndFinish();
		if (errTotal == 0 && testsRun > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#100000;
		errTotal++;
		tallyAndFinish();
	end
	initial begin
		rstn = 1'b0;
		clkEn = 1'b1;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		check_defaults();
		check_regions();
		check_disabled();
		check_stack();
		tallyAndFinish();
	end
endmodule
